// ---- logic/rfe_config.sv ----
// Receiver front-end configuration: input routing, strength readout, gain control and filter settings.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ns
`include "rfe_params.svh"
module rfe_config #(
  parameter int LW        = 8,
  parameter int DIG_LEVEL = 16
) (
  // Clock, reset and clock enable
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                clk_en,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Pins
  input  wire logic                enable_pin,
  input  wire logic                subcarrier_pulse,
  // Envelope levels of both inputs and the response window
  input  wire logic [LW-1:0]       rx_input_first,
  input  wire logic [LW-1:0]       rx_input_second,
  input  wire logic                tag_response,
  // Main path towards the digitizer
  output logic      [LW-1:0]       main_level,
  // Analog settings
  output rfe_pkg::rfe_rxset_t      rx_setting,
  output logic      [4:0]          gain_reduce_db,
  output logic                     band_default,
  output logic                     agc_active,
  output logic                     agc_reduce
);
  import rfe_pkg::*;

  // The strength field takes the top three bits of a level, so narrower levels cannot be served.
  if (LW < 3 || LW > 16) begin : g_bad_lw
    $error("rfe_config: LW must lie between 3 and 16");
  end
  if (DIG_LEVEL < 1 || DIG_LEVEL * `RFE_AGC_MULT_HIGH >= 2 ** (LW + 1)) begin : g_bad_dig_level
    $error("rfe_config: DIG_LEVEL does not fit the level width");
  end

  function automatic logic [7:0] byte_addr(input logic [3:0] idx);
    byte_addr = {2'b00, idx, 2'b00};
  endfunction

  function automatic logic [LW:0] agc_limit(input logic level3);
    agc_limit = level3 ? (LW+1)'(DIG_LEVEL * `RFE_AGC_MULT_LOW) : (LW+1)'(DIG_LEVEL * `RFE_AGC_MULT_HIGH);
  endfunction

  function automatic logic [4:0] reduce_db(input logic [7:0] set);
    logic [4:0] db;
    db = 5'(`RFE_GRED_STEP_DB) * {3'b000, set[`RFE_BIT_GRED_HI], set[`RFE_BIT_GRED_LO]};
    if (set[`RFE_BIT_BAND_WIDE]) begin
      db = 5'(`RFE_WIDE_GRED_DB);
    end
    reduce_db = db;
  endfunction

  logic [7:0]      chip_ctrl;
  logic [7:0]      proto_ctrl;
  logic [7:0]      rxset;
  rfe_rssi_t       rssi;
  rfe_bus_t        bus_state;
  logic            enabled;
  logic            pulse_level;
  logic            pulse_d;
  logic            resp_d;
  logic [3:0]      pulse_cnt;
  logic            agc_frozen;
  logic [LW-1:0]   aux_level;
  logic [LW-1:0]   main_peak;
  logic [LW-1:0]   aux_peak;
  logic            wr_commit;
  logic            proto_write;

  assign wr_commit   = clk_en && psel && penable && pready && pwrite;
  assign proto_write = wr_commit && (paddr == byte_addr(`RFE_IDX_PROTO_CTRL));

  rfe_sync3 u_sync_enable (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .pin     (enable_pin),
    .level   (enabled)
  );

  rfe_sync3 u_sync_pulse (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .pin     (subcarrier_pulse),
    .level   (pulse_level)
  );

  // Bus handshake: every access completes with one wait-free access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_state <= RFE_BUS_IDLE;
      pready    <= 1'b0;
    end else if (clk_en) begin
      unique case (bus_state)
        RFE_BUS_IDLE: begin
          if (psel && !penable) begin
            bus_state <= RFE_BUS_ACCESS;
            pready    <= 1'b1;
          end
        end
        RFE_BUS_ACCESS: begin
          bus_state <= RFE_BUS_IDLE;
          pready    <= 1'b0;
        end
      endcase
    end
  end

  // Read data and error are prepared in the setup cycle; unmapped addresses answer with an error.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      if (psel && !penable) begin
        pslverr <= 1'b0;
        prdata  <= 32'h0000_0000;
        if (paddr == byte_addr(`RFE_IDX_CHIP_CTRL)) begin
          prdata[7:0] <= pwrite ? 8'h00 : chip_ctrl;
        end else if (paddr == byte_addr(`RFE_IDX_PROTO_CTRL)) begin
          prdata[7:0] <= pwrite ? 8'h00 : proto_ctrl;
        end else if (paddr == byte_addr(`RFE_IDX_RXSET)) begin
          prdata[7:0] <= pwrite ? 8'h00 : rxset;
        end else if (paddr == byte_addr(`RFE_IDX_RSSI)) begin
          prdata[7:0] <= pwrite ? 8'h00 : {2'b00, rssi};
          pslverr     <= pwrite;
        end else begin
          pslverr <= 1'b1;
        end
      end else if (!psel) begin
        prdata  <= 32'h0000_0000;
        pslverr <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chip_ctrl <= `RFE_RST_CHIP_CTRL;
    end else if (clk_en && wr_commit && paddr == byte_addr(`RFE_IDX_CHIP_CTRL)) begin
      chip_ctrl <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      proto_ctrl <= `RFE_RST_PROTO_CTRL;
    end else if (proto_write) begin
      proto_ctrl <= pwdata[7:0];
    end
  end

  // Enable low or a protocol write presets the settings; direct writes refine them afterwards.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxset <= `RFE_RST_RXSET;
    end else if (clk_en) begin
      if (!enabled || proto_write) begin
        rxset <= `RFE_RST_RXSET;
      end else if (wr_commit && paddr == byte_addr(`RFE_IDX_RXSET)) begin
        rxset <= pwdata[7:0];
      end
    end
  end

  // Only the main path reaches the digitizer; the auxiliary level stays inside for monitoring.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_level <= '0;
      aux_level  <= '0;
    end else if (clk_en) begin
      main_level <= chip_ctrl[`RFE_BIT_SWAP] ? rx_input_second : rx_input_first;
      aux_level  <= chip_ctrl[`RFE_BIT_SWAP] ? rx_input_first : rx_input_second;
    end
  end

  rfe_rssi_meter #(
    .LW (LW)
  ) u_meter_main (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .active  (tag_response),
    .level   (main_level),
    .peak    (main_peak)
  );

  rfe_rssi_meter #(
    .LW (LW)
  ) u_meter_aux (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .active  (tag_response),
    .level   (aux_level),
    .peak    (aux_peak)
  );

  // Both strengths are published together when the response ends, so software never sees a mixed pair.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rssi   <= rfe_rssi_t'(6'(`RFE_RST_RSSI));
      resp_d <= 1'b0;
    end else if (clk_en) begin
      resp_d <= tag_response;
      if (resp_d && !tag_response) begin
        rssi.main <= main_peak[LW-1 -: 3];
        rssi.aux  <= aux_peak[LW-1 -: 3];
      end
    end
  end

  // Subcarrier pulses are counted per response to time the gain-control freeze.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_d   <= 1'b0;
      pulse_cnt <= 4'h0;
    end else if (clk_en) begin
      pulse_d <= pulse_level;
      if (!tag_response) begin
        pulse_cnt <= 4'h0;
      end else if (pulse_level && !pulse_d && pulse_cnt < 4'(`RFE_AGC_FREEZE_PULSES)) begin
        pulse_cnt <= pulse_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      agc_frozen <= 1'b0;
    end else if (clk_en) begin
      agc_frozen <= tag_response && !rxset[`RFE_BIT_NOLIM]
                    && (pulse_cnt == 4'(`RFE_AGC_FREEZE_PULSES));
    end
  end

  // Gain reduction is latched while the loop may act and held once frozen.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      agc_reduce <= 1'b0;
      agc_active <= 1'b0;
    end else if (clk_en) begin
      agc_active <= chip_ctrl[`RFE_BIT_AGC_EN] && !agc_frozen;
      if (!chip_ctrl[`RFE_BIT_AGC_EN] || (tag_response && !resp_d)) begin
        agc_reduce <= 1'b0;
      end else if (tag_response && !agc_frozen
                   && {1'b0, main_level} > agc_limit(rxset[`RFE_BIT_AGC_LEVEL3])) begin
        agc_reduce <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_setting     <= rfe_rxset_t'(`RFE_RST_RXSET);
      gain_reduce_db <= 5'h00;
      band_default   <= 1'b0;
    end else if (clk_en) begin
      rx_setting     <= rfe_rxset_t'(rxset);
      gain_reduce_db <= reduce_db(rxset);
      band_default   <= (rxset[7:4] == 4'h0);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  route_swap_a: assert property (clk_en && chip_ctrl[`RFE_BIT_SWAP] |=> main_level == $past(rx_input_second))
    else $error("main path not fed from second input while swapped");
  route_default_a: assert property (clk_en && !chip_ctrl[`RFE_BIT_SWAP] |=> main_level == $past(rx_input_first))
    else $error("main path not fed from first input by default");
  proto_reload_a: assert property (proto_write |=> rxset == `RFE_RST_RXSET)
    else $error("setting register not preset by protocol write");
  enable_reload_a: assert property (clk_en && !enabled |=> rxset == `RFE_RST_RXSET)
    else $error("setting register not preset while enable low");
  rssi_capture_a: assert property (clk_en && resp_d && !tag_response |=> rssi.main == $past(main_peak[LW-1 -: 3]))
    else $error("main strength not captured at response end");
  agc_off_a: assert property (clk_en && !chip_ctrl[`RFE_BIT_AGC_EN] |=> !agc_reduce && !agc_active)
    else $error("gain control acted while disabled");
  agc_freeze_a: assert property (clk_en && tag_response && !rxset[`RFE_BIT_NOLIM]
                                 && pulse_cnt == 4'(`RFE_AGC_FREEZE_PULSES) |=> agc_frozen || !clk_en)
    else $error("gain control not frozen after the pulse count");
  agc_nolim_a: assert property (clk_en && rxset[`RFE_BIT_NOLIM] |=> !agc_frozen)
    else $error("gain control frozen with no time limit");
  gain_db_a: assert property (clk_en && !rxset[4] && rxset[3:2] == 2'b11 |=> gain_reduce_db == 5'd15)
    else $error("wrong gain reduction for code 11");
  wide_db_a: assert property (clk_en && rxset[4] |=> gain_reduce_db == 5'd18)
    else $error("wide band gain reduction missing");
  band_default_a: assert property (clk_en && rxset[7:4] == 4'h0 |=> band_default)
    else $error("default band not flagged");
  threshold_a: assert property (clk_en && rxset[`RFE_BIT_AGC_LEVEL3] && chip_ctrl[`RFE_BIT_AGC_EN]
                                && tag_response && resp_d && !agc_frozen
                                && main_level > LW'(DIG_LEVEL * `RFE_AGC_MULT_LOW) |=> agc_reduce)
    else $error("gain not reduced above the 3x threshold");
  ready_pulse_a: assert property (clk_en && pready |=> !pready || !clk_en)
    else $error("ready held longer than one cycle");

  swap_seen_c: cover property (clk_en && chip_ctrl[`RFE_BIT_SWAP] && tag_response);
  reload_seen_c: cover property (proto_write ##1 rxset == `RFE_RST_RXSET);
  freeze_seen_c: cover property (agc_frozen && agc_reduce);
  rssi_seen_c: cover property (clk_en && resp_d && !tag_response);

endmodule // rfe_config

// ---- logic/rfe_rssi_meter.sv ----
// Peak-hold strength meter for one receive path over a tag response.
`timescale 1ns/1ns
module rfe_rssi_meter #(
  parameter int LW = 8
) (
  // Clock, reset and clock enable
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          clk_en,
  // Measurement
  input  wire logic          active,
  input  wire logic [LW-1:0] level,
  output logic      [LW-1:0] peak
);

  logic active_d;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_d <= 1'b0;
    end else if (clk_en) begin
      active_d <= active;
    end
  end

  // Each response starts a fresh peak so a strong old reply cannot mask a weak new one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peak <= '0;
    end else if (clk_en) begin
      if (active && !active_d) begin
        peak <= level;
      end else if (active && (level > peak)) begin
        peak <= level;
      end
    end
  end

endmodule // rfe_rssi_meter

// ---- logic/rfe_sync3.sv ----
// Three-stage pin synchroniser that accepts a new level once the last two stages agree.
`timescale 1ns/1ns
module rfe_sync3 (
  // Clock, reset and clock enable
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  // Pin and settled level
  input  wire logic pin,
  output logic      level
);

  logic stage1;
  logic stage2;
  logic stage3;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else if (clk_en) begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A single-cycle disagreement between stages two and three leaves the level unchanged.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= 1'b0;
    end else if (clk_en && (stage2 == stage3)) begin
      level <= stage3;
    end
  end

endmodule // rfe_sync3

// ---- shared/rfe_params.svh ----
// Register offsets, field positions, reset values and counts of the receiver front-end configuration block.
`ifndef RFE_PARAMS_SVH
`define RFE_PARAMS_SVH

// Register indices; the byte address on the bus is four times the index.
`define RFE_IDX_CHIP_CTRL  4'h0
`define RFE_IDX_PROTO_CTRL 4'h1
`define RFE_IDX_RXSET      4'hA
`define RFE_IDX_RSSI       4'hF

// Reset values.
`define RFE_RST_CHIP_CTRL  8'h00
`define RFE_RST_PROTO_CTRL 8'h00
`define RFE_RST_RXSET      8'h40
`define RFE_RST_RSSI       8'h00

// Chip status control fields.
`define RFE_BIT_SWAP       3
`define RFE_BIT_AGC_EN     2

// Gain and filter setting fields.
`define RFE_BIT_BAND_LOW   7
`define RFE_BIT_BAND_MID   6
`define RFE_BIT_BAND_HIGH  5
`define RFE_BIT_BAND_WIDE  4
`define RFE_BIT_GRED_HI    3
`define RFE_BIT_GRED_LO    2
`define RFE_BIT_AGC_LEVEL3 1
`define RFE_BIT_NOLIM      0

// Signal-strength field positions.
`define RFE_RSSI_MAIN_LSB  0
`define RFE_RSSI_AUX_LSB   3

// Gain control and gain reduction figures.
`define RFE_AGC_FREEZE_PULSES 8
`define RFE_AGC_MULT_LOW      3
`define RFE_AGC_MULT_HIGH     5
`define RFE_GRED_STEP_DB      5
`define RFE_WIDE_GRED_DB      18

`endif

// ---- shared/rfe_pkg.sv ----
// Types shared by the receiver front-end configuration block.
package rfe_pkg;

  // Decoded view of the gain and filter setting register.
  typedef struct packed {
    logic       band_low_sel;
    logic       band_mid_sel;
    logic       band_high_sel;
    logic       band_wide_sel;
    logic       gain_reduce_hi;
    logic       gain_reduce_lo;
    logic       agc_level3;
    logic       agc_nolim;
  } rfe_rxset_t;

  // Quantised signal strength of both paths.
  typedef struct packed {
    logic [2:0] aux;
    logic [2:0] main;
  } rfe_rssi_t;

  typedef enum logic [1:0] {
    RFE_BUS_IDLE,
    RFE_BUS_ACCESS
  } rfe_bus_t;

endpackage

// ---- verification/rfe_config_tb.sv ----
// Self-checking testbench for the receiver front-end configuration block.
`timescale 1ns/1ns
`include "rfe_params.svh"
module rfe_config_tb;
  import rfe_pkg::*;

  localparam int         LW        = 8;
  localparam int         DIG_LEVEL = 16;
  localparam logic [7:0] A_CTRL    = 8'(`RFE_IDX_CHIP_CTRL * 4);
  localparam logic [7:0] A_PROTO   = 8'(`RFE_IDX_PROTO_CTRL * 4);
  localparam logic [7:0] A_SET     = 8'(`RFE_IDX_RXSET * 4);
  localparam logic [7:0] A_RSSI    = 8'(`RFE_IDX_RSSI * 4);

  logic              pclk             = 1'b0;
  logic              presetn          = 1'b0;
  logic              clk_en           = 1'b1;
  logic              psel             = 1'b0;
  logic              penable          = 1'b0;
  logic              pwrite           = 1'b0;
  logic [7:0]        paddr            = 8'h00;
  logic [31:0]       pwdata           = 32'h0000_0000;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              enable_pin       = 1'b1;
  logic              subcarrier_pulse = 1'b0;
  logic [LW-1:0]     rx_input_first   = 8'h00;
  logic [LW-1:0]     rx_input_second  = 8'h00;
  logic              tag_response     = 1'b0;
  logic [LW-1:0]     main_level;
  rfe_rxset_t        rx_setting;
  logic [4:0]        gain_reduce_db;
  logic              band_default;
  logic              agc_active;
  logic              agc_reduce;
  int                n_fail           = 0;
  int                num_checks       = 0;
  logic [31:0]       rdata;
  logic              rerr;

  rfe_config #(.LW(LW), .DIG_LEVEL(DIG_LEVEL)) u_dut (
    .pclk             (pclk),
    .presetn          (presetn),
    .clk_en           (clk_en),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .paddr            (paddr),
    .pwdata           (pwdata),
    .prdata           (prdata),
    .pready           (pready),
    .pslverr          (pslverr),
    .enable_pin       (enable_pin),
    .subcarrier_pulse (subcarrier_pulse),
    .rx_input_first   (rx_input_first),
    .rx_input_second  (rx_input_second),
    .tag_response     (tag_response),
    .main_level       (main_level),
    .rx_setting       (rx_setting),
    .gain_reduce_db   (gain_reduce_db),
    .band_default     (band_default),
    .agc_active       (agc_active),
    .agc_reduce       (agc_reduce)
  );

  always #10 pclk = ~pclk;

  task automatic summarize;
    $display("Checks: %0d, mismatches: %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t ns: seen 0x%08h, expected 0x%08h", $time, seen, exp);
    end
  endtask

  // Holds the request until pready is sampled high, then takes data and response at that edge.
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                     output logic [31:0] data, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    data    = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] wdata);
    apb(1'b1, addr, wdata, rdata, rerr);
    chk(32'(rerr), 32'h0000_0000);
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0000_0000, rdata, rerr);
    chk(32'(rerr), 32'h0000_0000);
    chk(rdata, exp);
  endtask

  // One tag response with the gain control set up; the pulses arrive slow enough for the synchroniser.
  task automatic agc_run(input logic [7:0] ctrl, input logic [7:0] set, input logic [7:0] lvl,
                         input logic exp_red, input logic exp_on, input logic exp_after);
    wr(A_CTRL, 32'(ctrl));
    wr(A_SET, 32'(set));
    rx_input_first <= lvl;
    tag_response   <= 1'b1;
    tick(6);
    chk(32'(agc_active), 32'(exp_on));
    chk(32'(agc_reduce), 32'(exp_red));
    for (int i = 0; i < `RFE_AGC_FREEZE_PULSES; i++) begin
      subcarrier_pulse <= 1'b1;
      tick(4);
      subcarrier_pulse <= 1'b0;
      tick(4);
    end
    tick(6);
    chk(32'(agc_active), 32'(exp_after));
    chk(32'(agc_reduce), 32'(exp_red));
    tag_response <= 1'b0;
    tick(3);
  endtask

  initial begin
    #200000;
    n_fail++;
    $display("[ERR] %0t ns: watchdog expired", $time);
    summarize();
  end

  initial begin
    tick(3);
    presetn <= 1'b1;
    tick(6);
    chk(32'(rx_setting), 32'h0000_0040);
    rd_chk(A_SET, 32'h0000_0040);
    rd_chk(A_CTRL, 32'h0000_0000);
    for (int g = 0; g < 4; g++) begin
      wr(A_SET, 32'(g << 2));
      tick(2);
      chk(32'(gain_reduce_db), 32'(g * `RFE_GRED_STEP_DB));
      chk(32'(band_default), 32'h0000_0001);
    end
    for (int b = 4; b < 8; b++) begin
      wr(A_SET, 32'(1 << b));
      tick(2);
      rd_chk(A_SET, 32'(1 << b));
      chk(32'(rx_setting), 32'(1 << b));
      chk(32'(band_default), 32'h0000_0000);
      chk(32'(gain_reduce_db), (b == 4) ? 32'(`RFE_WIDE_GRED_DB) : 32'h0000_0000);
    end
    // A protocol write reloads the preset; refinement has to come after it.
    wr(A_SET, 32'h0000_00A5);
    wr(A_PROTO, 32'h0000_0001);
    rd_chk(A_SET, 32'h0000_0040);
    wr(A_SET, 32'h0000_0022);
    rd_chk(A_SET, 32'h0000_0022);
    enable_pin <= 1'b0;
    tick(6);
    rd_chk(A_SET, 32'h0000_0040);
    wr(A_SET, 32'h0000_0010);
    rd_chk(A_SET, 32'h0000_0040);
    enable_pin <= 1'b1;
    tick(6);
    apb(1'b1, A_RSSI, 32'h0000_00FF, rdata, rerr);
    chk(32'(rerr), 32'h0000_0001);
    apb(1'b0, 8'h10, 32'h0000_0000, rdata, rerr);
    chk(32'(rerr), 32'h0000_0001);
    rx_input_first  <= 8'h11;
    rx_input_second <= 8'h22;
    tick(3);
    chk(32'(main_level), 32'h0000_0011);
    wr(A_CTRL, 32'(1 << `RFE_BIT_SWAP));
    tick(3);
    chk(32'(main_level), 32'h0000_0022);
    // With the clock enable low the main path must hold its last value.
    clk_en          <= 1'b0;
    rx_input_second <= 8'h33;
    tick(3);
    chk(32'(main_level), 32'h0000_0022);
    clk_en <= 1'b1;
    tick(2);
    chk(32'(main_level), 32'h0000_0033);
    wr(A_CTRL, 32'h0000_0000);
    rx_input_first  <= 8'hE0;
    rx_input_second <= 8'h20;
    // The routed levels lag one cycle; let them settle before the response opens.
    tick(2);
    tag_response    <= 1'b1;
    tick(5);
    tag_response <= 1'b0;
    tick(3);
    rd_chk(A_RSSI, 32'h0000_000F);
    // The auxiliary path was weaker here, but swapping shows both fields follow the routing.
    wr(A_CTRL, 32'(1 << `RFE_BIT_SWAP));
    tick(2);
    tag_response <= 1'b1;
    tick(5);
    tag_response <= 1'b0;
    tick(3);
    rd_chk(A_RSSI, 32'h0000_0039);
    agc_run(8'h04, 8'h00, 8'd100, 1'b1, 1'b1, 1'b0);
    agc_run(8'h04, 8'h01, 8'd100, 1'b1, 1'b1, 1'b1);
    agc_run(8'h04, 8'h02, 8'd60, 1'b1, 1'b1, 1'b0);
    agc_run(8'h04, 8'h00, 8'd60, 1'b0, 1'b1, 1'b0);
    agc_run(8'h00, 8'h01, 8'd100, 1'b0, 1'b0, 1'b0);
    summarize();
  end
endmodule // rfe_config_tb
